//--- core/fcs_ctrl.sv
// Host controller that drives an asynchronous NOR flash over its pins.
// Assumes software orders bus cycles over APB; flash data input is async.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Reads: chip, output enable low; others high.
// - Identification code goes to address zero.
// - After identification, read array code first.
// - Query code goes to address zero.
// - Status read is command write, then read.
// - Suspended program: never read the programmed word; only OP_READ of it is refused, not the read of OP_CMDREAD.
// - Erase is setup then confirm code.
// - Erase-suspended: may program elsewhere, then resume.
module fcs_ctrl
  import fcs_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEF
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic [7:0]        paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Flash pins
  output logic      [ADDR_W-1:0] flash_addr,
  output logic      [DATA_W-1:0] flash_dq_out,
  output logic                   flash_dq_oe,
  input  wire logic [DATA_W-1:0] flash_dq_in,
  output logic                   flash_ce_n,
  output logic                   flash_oe_n,
  output logic                   flash_we_n,
  output logic                   flash_rst_n
);

  fcs_state_t state;
  fcs_state_t next_state;

  logic [7:0]        cmd_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] data_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [ADDR_W-1:0] prog_addr;
  logic [DATA_W-1:0] dq_s1;
  logic [DATA_W-1:0] dq_s2;
  logic [7:0]        last_code;
  logic [2:0]        op_q;
  logic              ph;
  logic              refused;
  logic              id_mode;
  logic              prog_active;
  logic              prog_susp;

  // APB decode
  wire apb_wr     = psel && penable && pwrite;
  wire sel_ctrl   = (paddr == REG_CTRL);
  wire sel_cmd    = (paddr == REG_CMD);
  wire sel_addr   = (paddr == REG_ADDR);
  wire sel_data   = (paddr == REG_DATA);
  wire sel_rdata  = (paddr == REG_RDATA);
  wire sel_status = (paddr == REG_STATUS);
  wire unmapped   = !(sel_ctrl || sel_cmd || sel_addr || sel_data ||
                      sel_rdata || sel_status);
  wire busy       = (state != S_IDLE);
  // Operands are frozen while a cycle runs, so later writes are refused
  wire locked_wr  = apb_wr && busy && (sel_ctrl || sel_cmd || sel_addr ||
                                       sel_data);
  wire wr_ok      = apb_wr && !busy;

  // Request check at the control write
  wire [2:0] new_op    = pwdata[2:0];
  wire       op_ok     = (new_op >= OP_WRITE1) && (new_op <= OP_RESET);
  wire [7:0] first_code = (new_op == OP_WRITE1) ? data_reg[7:0] : cmd_reg;
  wire       has_write = (new_op == OP_WRITE1) || (new_op == OP_WRITE2) ||
                         (new_op == OP_CMDREAD);
  wire bad_id   = id_mode && has_write &&
                  (first_code != CODE_READ_ARRAY);
  wire bad_susp = prog_susp && (new_op == OP_READ) &&
                  (addr_reg == prog_addr);
  wire go_req   = wr_ok && sel_ctrl;
  wire start    = go_req && op_ok && !bad_id && !bad_susp;
  wire refuse   = go_req && !start;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && (unmapped || locked_wr || refuse);

  wire [31:0] status_word = {27'h000_0000, prog_active, prog_susp,
                             id_mode, refused, busy};
  wire [31:0] rd_mux =
    sel_ctrl   ? {29'h0000_0000, op_q} :
    sel_cmd    ? {24'h00_0000, cmd_reg} :
    sel_addr   ? 32'(addr_reg) :
    sel_data   ? {16'h0000, data_reg} :
    sel_rdata  ? {16'h0000, rdata_reg} :
    sel_status ? status_word : 32'h0000_0000;

  // Current bus cycle
  wire cyc_read = (!ph && (op_q == OP_READ)) ||
                  (ph && (op_q == OP_CMDREAD));
  wire [DATA_W-1:0] word0 = (op_q == OP_WRITE1) ? data_reg :
                            {8'h00, cmd_reg};
  wire [DATA_W-1:0] word1 = (cmd_reg == CODE_ERASE) ?
                            {8'h00, CODE_CONFIRM} : data_reg;
  wire [DATA_W-1:0] cyc_word = ph ? word1 : word0;
  wire [7:0] cyc_code = cyc_word[7:0];
  wire force0 = !cyc_read && !ph &&
                ((cyc_code == CODE_READ_ID) ||
                 (cyc_code == CODE_QUERY) ||
                 (id_mode && (cyc_code == CODE_READ_ARRAY)));
  wire [ADDR_W-1:0] cyc_addr = force0 ? '0 : addr_reg;
  wire last_ph = ph || (op_q == OP_WRITE1) || (op_q == OP_READ);
  wire in_cycle = (state == S_SETUP) || (state == S_STROBE) ||
                  (state == S_HOLD);

  logic expire;
  wire wr_done = (state == S_STROBE) && expire && !cyc_read;
  wire rd_done = (state == S_STROBE) && expire && cyc_read;
  wire rst_done = (state == S_RST) && expire;
  wire prog_word = ph && (op_q == OP_WRITE2) &&
                   ((cmd_reg == CODE_PROG) || (cmd_reg == CODE_PROG_ALT));
  wire ready_seen = rd_done && (op_q == OP_CMDREAD) &&
                    (cmd_reg == CODE_STATUS) &&
                    dq_s2[DEV_READY_BIT] && !dq_s2[DEV_PSUSP_BIT];

  always_comb begin
    next_state = state;
    unique case (state)
      S_IDLE:   if (start) next_state = (new_op == OP_RESET) ? S_RST : S_SETUP;
      S_SETUP:  if (expire) next_state = S_STROBE;
      S_STROBE: if (expire) next_state = S_HOLD;
      S_HOLD:   if (expire) next_state = last_ph ? S_IDLE : S_SETUP;
      S_RST:    if (expire) next_state = S_IDLE;
    endcase
  end

  wire tmr_load = (next_state != state);
  wire [7:0] tmr_count =
    (next_state == S_SETUP)  ? CYC_SU :
    (next_state == S_STROBE) ? (cyc_read ? CYC_RD : CYC_WP) :
    (next_state == S_HOLD)   ? CYC_HD :
    (next_state == S_RST)    ? CYC_RST : CYC_NONE;

  fcs_tmr #(.W(8)) u_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (tmr_load),
    .count   (tmr_count),
    .expire  (expire)
  );

  // Sequencer and operand registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      op_q  <= 3'h0;
      ph    <= 1'b0;
    end else begin
      state <= next_state;
      if (start) begin
        op_q <= new_op;
        ph   <= 1'b0;
      end else if ((state == S_HOLD) && expire && !last_ph) begin
        ph <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg  <= 8'h00;
      addr_reg <= '0;
      data_reg <= 16'h0000;
      prdata   <= 32'h0000_0000;
    end else begin
      if (wr_ok && sel_cmd) cmd_reg <= pwdata[7:0];
      if (wr_ok && sel_addr) addr_reg <= pwdata[ADDR_W-1:0];
      if (wr_ok && sel_data) data_reg <= pwdata[DATA_W-1:0];
      if (psel && !penable) prdata <= rd_mux;
    end
  end

  // Refused flag: a new refusal wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refused <= 1'b0;
    end else if (refuse) begin
      refused <= 1'b1;
    end else if (wr_ok && sel_status && pwdata[ST_REFUSED]) begin
      refused <= 1'b0;
    end
  end

  // Tracking of the device mode as seen from here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_mode     <= 1'b0;
      prog_active <= 1'b0;
      prog_susp   <= 1'b0;
      prog_addr   <= '0;
      last_code   <= 8'h00;
      rdata_reg   <= 16'h0000;
    end else if (rst_done) begin
      id_mode     <= 1'b0;
      prog_active <= 1'b0;
      prog_susp   <= 1'b0;
    end else begin
      if (wr_done) begin
        last_code <= cyc_code;
        if ((cyc_code == CODE_READ_ID) || (cyc_code == CODE_QUERY)) begin
          id_mode <= !ph;
        end else if (!ph && (cyc_code == CODE_READ_ARRAY)) begin
          id_mode <= 1'b0;
        end
        if (prog_word) begin
          prog_active <= 1'b1;
          prog_addr   <= addr_reg;
        end
        if (!ph && prog_active && (cyc_code == CODE_SUSPEND)) begin
          prog_susp <= 1'b1;
        end else if (!ph && (cyc_code == CODE_CONFIRM)) begin
          prog_susp <= 1'b0;
        end
      end
      if (rd_done) rdata_reg <= dq_s2;
      if (ready_seen) prog_active <= 1'b0;
    end
  end

  // Data bus input synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1 <= 16'h0000;
      dq_s2 <= 16'h0000;
    end else begin
      dq_s1 <= flash_dq_in;
      dq_s2 <= dq_s1;
    end
  end

  // Pins are a registered image of the sequencer, one cycle late
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_ce_n   <= 1'b1;
      flash_oe_n   <= 1'b1;
      flash_we_n   <= 1'b1;
      flash_rst_n  <= 1'b1;
      flash_dq_oe  <= 1'b0;
      flash_addr   <= '0;
      flash_dq_out <= 16'h0000;
    end else begin
      flash_ce_n  <= !in_cycle;
      flash_oe_n  <= !((state == S_STROBE) && cyc_read);
      flash_we_n  <= !((state == S_STROBE) && !cyc_read);
      flash_rst_n <= (state != S_RST);
      flash_dq_oe <= in_cycle && !cyc_read;
      if (state == S_SETUP) begin
        flash_addr   <= cyc_addr;
        flash_dq_out <= cyc_word;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_read_strobes: assert property (!flash_oe_n |->
    !flash_ce_n && flash_we_n && flash_rst_n && !flash_dq_oe)
    else $error("read strobe with wrong control levels");
  a_read_width: assert property ($fell(flash_oe_n) |->
    !flash_oe_n [*5] ##1 flash_oe_n)
    else $error("read strobe width wrong");
  a_id_bank: assert property ($fell(flash_we_n) && !ph &&
    (flash_dq_out[7:0] == CODE_READ_ID) |-> (flash_addr == '0))
    else $error("identification code not at address zero");
  a_query_bank: assert property ($fell(flash_we_n) && !ph &&
    (flash_dq_out[7:0] == CODE_QUERY) |-> (flash_addr == '0))
    else $error("query code not at address zero");
  a_id_exit: assert property ($fell(flash_we_n) && id_mode |->
    (flash_dq_out[7:0] == CODE_READ_ARRAY) && (flash_addr == '0))
    else $error("command other than read array after identification");
  a_status_pair: assert property ($fell(flash_oe_n) &&
    (op_q == OP_CMDREAD) && (cmd_reg == CODE_STATUS) |->
    (last_code == CODE_STATUS))
    else $error("status read without status command");
  a_susp_addr: assert property (!flash_oe_n && prog_susp |->
    (flash_addr != prog_addr))
    else $error("read of suspended word");
  a_erase_confirm: assert property ($fell(flash_we_n) && ph &&
    (op_q == OP_WRITE2) && (cmd_reg == CODE_ERASE) |->
    (flash_dq_out == {8'h00, CODE_CONFIRM}))
    else $error("erase setup not followed by confirm");

  c_erase_seq: cover property ($fell(flash_we_n) && ph &&
    (cmd_reg == CODE_ERASE));
  c_status_read: cover property (ready_seen);
  c_reset_op: cover property ($fell(flash_rst_n));
  c_refused: cover property (refuse && bad_id);

endmodule // fcs_ctrl
`default_nettype wire

//--- core/fcs_pkg.sv
// Constants, codes and timing for the flash bus controller.
// Assumes a 20 MHz pclk; all pin timing is counted in pclk cycles.
package fcs_pkg;

  // Flash bus widths
  localparam int ADDR_W_DEF = 21;
  localparam int DATA_W     = 16;

  // APB register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_CMD    = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;
  localparam logic [7:0] REG_DATA   = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  // Operation codes written to the control register
  localparam logic [2:0] OP_WRITE1  = 3'h1;
  localparam logic [2:0] OP_WRITE2  = 3'h2;
  localparam logic [2:0] OP_READ    = 3'h3;
  localparam logic [2:0] OP_CMDREAD = 3'h4;
  localparam logic [2:0] OP_RESET   = 3'h5;

  // Flash command codes
  localparam logic [7:0] CODE_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CODE_READ_ID    = 8'h90;
  localparam logic [7:0] CODE_QUERY      = 8'h98;
  localparam logic [7:0] CODE_STATUS     = 8'h70;
  localparam logic [7:0] CODE_ERASE      = 8'h20;
  localparam logic [7:0] CODE_CONFIRM    = 8'hD0;
  localparam logic [7:0] CODE_PROG       = 8'h40;
  localparam logic [7:0] CODE_PROG_ALT   = 8'h10;
  localparam logic [7:0] CODE_SUSPEND    = 8'hB0;

  // Status register bit positions
  localparam int ST_BUSY    = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_ID      = 2;
  localparam int ST_PSUSP   = 3;
  localparam int ST_PACTIVE = 4;

  // Device status bits seen on the data bus
  localparam int DEV_READY_BIT = 7;
  localparam int DEV_PSUSP_BIT = 2;

  // Pin timing in ns
  localparam int CLK_NS   = 50;
  localparam int T_SU_NS  = 20;
  localparam int T_WP_NS  = 70;
  localparam int T_ACC_NS = 80;
  localparam int T_HD_NS  = 20;
  localparam int T_RST_NS = 100;
  localparam int SYNC_STAGES = 2;

  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Read strobe also covers the pin register stage and the synchroniser
  localparam logic [7:0] CYC_SU  = 8'(cyc_up(T_SU_NS));
  localparam logic [7:0] CYC_WP  = 8'(cyc_up(T_WP_NS));
  localparam logic [7:0] CYC_RD  = 8'(cyc_up(T_ACC_NS) + SYNC_STAGES + 1);
  localparam logic [7:0] CYC_HD  = 8'(cyc_up(T_HD_NS));
  localparam logic [7:0] CYC_RST = 8'(cyc_up(T_RST_NS));
  localparam logic [7:0] CYC_NONE = 8'h00;

  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_STROBE, S_HOLD, S_RST
  } fcs_state_t;

endpackage

//--- core/fcs_tmr.sv
// Down counter that times one phase of a flash bus cycle.
// Assumes load comes from the controller on the same clock.
`timescale 1ns/10ps
`default_nettype none
module fcs_tmr
  import fcs_pkg::*;
#(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              expire
);

  logic [W-1:0] cnt;

  // Expires in the last cycle of a phase of count cycles
  assign expire = (cnt == W'(1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= '0;
    end else if (load) begin
      cnt <= count;
    end else if (cnt != '0) begin
      cnt <= cnt - W'(1);
    end
  end

endmodule // fcs_tmr
`default_nettype wire

//--- dv/fcs_flash_model.sv
// Flash device model: command decode, status, locks, timed engine.
// Assumes the controller's pins; strobes only, no clock pin; the engine ticks every 10 ns.
`timescale 1ns/10ps
`default_nettype none
module fcs_flash_model
  import fcs_pkg::*;
#(
  parameter int          BUSY_NS = 6000,
  parameter logic [15:0] MFR_ID  = 16'h00A5, // Arbitrary value
  parameter logic [15:0] DEV_ID  = 16'h005A  // Arbitrary value
) (
  // Pins from the controller
  input  wire logic [20:0] flash_addr,
  input  wire logic [15:0] flash_dq_out,
  input  wire logic        flash_dq_oe,
  input  wire logic        flash_ce_n,
  input  wire logic        flash_oe_n,
  input  wire logic        flash_we_n,
  input  wire logic        flash_rst_n,
  // Bench knobs and data back
  input  wire logic        vpp_ok,
  input  wire logic        slow,
  output logic      [15:0] flash_dq_in
);
  // Modes: 0 array, 1 status, 2 ident, 3 query
  logic [15:0] mem [int] = '{default: 16'hFFFF};
  logic [1:0]  lk [int] = '{default: 2'h0};
  logic [7:0]  sr = 8'h00;
  logic [7:0]  pend = 8'h00;
  logic [1:0]  mode = 2'h0;
  logic        busy = 1'b0;
  logic        susp = 1'b0;
  logic        ers = 1'b0;
  int          left, oa, ra;
  logic [15:0] od;
  initial flash_dq_in = 16'h0000;
  function automatic int blk(input int a);
    return a >> 12;
  endfunction
  function automatic logic [15:0] rd(input int a);
    case (mode)
      2'h0: return mem[a];
      2'h1: return {8'h00, sr | {!busy || susp, susp && ers, 3'h0,
                                 susp && !ers, 2'h0}};
      2'h2: return a == 0 ? MFR_ID : a == 1 ? DEV_ID : 16'(lk[blk(a)]);
      default: return 16'h0051 ^ 16'(a[7:0]);
    endcase
  endfunction
  task automatic start(input int a, input logic [15:0] d, input logic e);
    mode = 2'h1;
    if (!vpp_ok) sr[3] = 1'b1;
    else if (lk[blk(a)] != 2'h0) sr[1] = 1'b1;
    else if (susp) mem[a] = mem[a] & d;
    else begin
      busy = 1'b1;
      ers = e;
      oa = a;
      od = d;
      left = BUSY_NS / 10;
    end
  endtask
  task automatic cmd1(input logic [7:0] c);
    case (c)
      8'hFF: mode = 2'h0;
      8'h70: mode = 2'h1;
      8'h90: mode = 2'h2;
      8'h98: mode = 2'h3;
      8'h50: sr = 8'h00;
      8'hD0: susp = 1'b0;
      8'h20, 8'h40, 8'h10, 8'h60: pend = c;
      default: pend = 8'h00;
    endcase
    if (c == 8'h50) mode = 2'h0;
  endtask
  task automatic wcmd(input int a, input logic [15:0] d);
    logic [7:0] p;
    p = pend;
    pend = 8'h00;
    if (p == CODE_PROG || p == CODE_PROG_ALT) start(a, d, 1'b0);
    else if (p == CODE_ERASE) begin
      if (d[7:0] == CODE_CONFIRM) start(a, d, 1'b1);
      else mode = 2'h1;
    end else if (p == 8'h60) begin
      if (d[7:0] == 8'h01) lk[blk(a)] = 2'h1;
      else if (d[7:0] == 8'h2F) lk[blk(a)] = 2'h2;
      else if (d[7:0] == 8'hD0 && lk[blk(a)] != 2'h2) lk[blk(a)] = 2'h0;
    end else if (busy && !susp) begin
      if (d[7:0] == CODE_STATUS) mode = 2'h1;
      if (d[7:0] == CODE_SUSPEND) susp = 1'b1;
    end else if (!busy || d[7:0] inside {8'hFF, 8'h70, 8'h90, 8'h98,
             8'h40, 8'h10, 8'hD0} || (ers && d[7:0] == 8'h60))
      cmd1(d[7:0]);
  endtask
  always @(posedge flash_we_n)
    if (!flash_ce_n && flash_rst_n && flash_dq_oe)
      wcmd(int'(flash_addr), flash_dq_out);
  always #10 begin
    if (busy && !susp) left--;
    if (busy && left == 0) begin
      busy = 1'b0;
      if (!ers) mem[oa] = mem[oa] & od;
      else foreach (mem[i]) if (blk(i) == blk(oa)) mem[i] = 16'hFFFF;
    end
  end
  // Data only after the later falling strobe
  always @(negedge flash_oe_n or negedge flash_ce_n)
    if (!flash_oe_n && !flash_ce_n && flash_we_n && flash_rst_n) begin
      ra = int'(flash_addr);
      #(slow ? 80 : 20) flash_dq_in = rd(ra);
    end
  // Released bus shows no stale value
  always @(posedge flash_oe_n or posedge flash_ce_n)
    flash_dq_in = ~flash_dq_in;
  always @(negedge flash_rst_n) begin
    busy = 1'b0;
    susp = 1'b0;
    pend = 8'h00;
    mode = 2'h0;
  end
endmodule // fcs_flash_model
`default_nettype wire

//--- dv/fcs_ctrl_tb_top.sv
// Bench: controller and flash model, orders sent over APB.
// Assumes fcs_pkg and the model; expectations come from the rules.
`timescale 1ns/10ps
`default_nettype none
module fcs_ctrl_tb_top
  import fcs_pkg::*;
;
  localparam logic [15:0] MFR = 16'h00A5; // Arbitrary value
  localparam logic [15:0] DEV = 16'h005A; // Arbitrary value
  localparam logic [31:0] CLR = 32'h0000_0002;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        vpp_ok, slow, flash_dq_oe;
  logic        flash_ce_n, flash_oe_n, flash_we_n, flash_rst_n;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [31:0] seed = 32'h0000_CCC9;
  logic [20:0] flash_addr;
  logic [15:0] flash_dq_out, flash_dq_in, d1;
  int          errors, n_compared, cyc, a1, a2;
  fcs_ctrl u_fcs_ctrl (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .flash_addr, .flash_dq_out,
    .flash_dq_oe, .flash_dq_in, .flash_ce_n, .flash_oe_n, .flash_we_n,
    .flash_rst_n);
  fcs_flash_model u_fcs_flash_model (.flash_addr, .flash_dq_out,
    .flash_dq_oe, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_rst_n,
    .vpp_ok, .slow, .flash_dq_in);
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      errors++;
      print_verdict();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Device status word: ready, erase/program suspended, lock, voltage
  function automatic logic [31:0] st(input logic rdy, es, ps, bl, vp);
    return {24'h00_0000, rdy, es, 2'h0, vp, ps, bl, 1'b0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
    end
  endtask
  // One APB transfer; r and e take the answer at the pready edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask
  // Loads CMD, ADDR, DATA, starts op, waits, then r holds RDATA
  task automatic op(input logic [2:0] o, input logic [7:0] c, input int a,
                    input logic [15:0] d);
    slow <= 1'(rnd());
    apb(1'b1, REG_CMD, {24'h00_0000, c});
    apb(1'b1, REG_ADDR, a);
    apb(1'b1, REG_DATA, {16'h0000, d});
    apb(1'b1, REG_CTRL, {29'h0, o});
    repeat (40) begin
      apb(1'b0, REG_STATUS, '0);
      if (r[ST_BUSY] === 1'b0) break;
    end
    apb(1'b0, REG_RDATA, '0);
  endtask
  task automatic poll(input int a);
    repeat (40) begin
      op(OP_CMDREAD, CODE_STATUS, a, '0);
      if (r[7] === 1'b1) break;
    end
  endtask
  task automatic print_verdict();
    if (errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, slow, paddr, pwdata} = '0;
    vpp_ok = 1'b1;
    {errors, n_compared, cyc} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, REG_STATUS, '0);
    chk("status_reset", '0, r);
    chk("ce_idle", 1, flash_ce_n);
    apb(1'b0, 8'h3C, '0);
    chk("unmapped_err", 1, e);
    a1 = (rnd() & 32'h001F_F000) | 32'h0010_0000;
    a2 = a1 ^ 32'h0000_1000;
    op(OP_READ, '0, a1, '0);
    chk("erased_word", 16'hFFFF, r);
    for (int k = 0; k < 2; k++) begin
      d1 = 16'(rnd());
      op(OP_WRITE2, k ? CODE_PROG_ALT : CODE_PROG, a1 + k, d1);
      op(OP_WRITE1, '0, a1, 16'h00FF);
      op(OP_READ, '0, a1, '0);
      chk("busy_status", st(1'b0, 1'b0, 1'b0, 1'b0, 1'b0), r);
      poll(a1);
      op(OP_WRITE1, '0, a1, 16'h00FF);
      op(OP_READ, '0, a1 + k, '0);
      chk("programmed", d1, r);
    end
    d1 = 16'(rnd());
    op(OP_WRITE2, CODE_PROG, a1 + 4, d1);
    op(OP_WRITE1, '0, a1, 16'h00B0);
    op(OP_CMDREAD, CODE_STATUS, a1, '0);
    chk("psusp_status", st(1'b1, 1'b0, 1'b1, 1'b0, 1'b0), r);
    op(OP_WRITE1, '0, a2, 16'h00FF);
    op(OP_READ, '0, a2, '0);
    chk("psusp_read", 16'hFFFF, r);
    op(OP_READ, '0, a1 + 4, '0);
    apb(1'b0, REG_STATUS, '0);
    chk("own_word", 32'h0000_001A, r);
    apb(1'b1, REG_STATUS, CLR);
    op(OP_WRITE1, '0, a1, 16'h00D0);
    poll(a1);
    op(OP_WRITE1, '0, a1, 16'h00FF);
    op(OP_READ, '0, a1 + 4, '0);
    chk("resumed", d1, r);
    op(OP_WRITE1, '0, a1, 16'h0020);
    op(OP_WRITE1, '0, a1, 16'h00FF);
    op(OP_READ, '0, a1, '0);
    chk("erase_refused", st(1'b1, 1'b0, 1'b0, 1'b0, 1'b0), r);
    op(OP_WRITE2, CODE_ERASE, a1 + 8, '0);
    op(OP_WRITE1, '0, a1, 16'h00B0);
    op(OP_CMDREAD, CODE_STATUS, a1, '0);
    chk("esusp_status", st(1'b1, 1'b1, 1'b0, 1'b0, 1'b0), r);
    d1 = 16'(rnd());
    op(OP_WRITE2, CODE_PROG, a2, d1);
    op(OP_WRITE1, '0, a1, 16'h00D0);
    poll(a1);
    op(OP_WRITE1, '0, a1, 16'h00FF);
    op(OP_READ, '0, a1, '0);
    chk("erased", 16'hFFFF, r);
    op(OP_READ, '0, a2, '0);
    chk("prog_in_esusp", d1, r);
    for (int k = 0; k < 3; k++) begin
      d1 = 16'(rnd());
      op(OP_WRITE2, 8'h60, (k + 3) << 12, k == 1 ? 16'h002F : 16'h0001);
      if (k > 0) op(OP_WRITE2, 8'h60, (k + 3) << 12, 16'h00D0);
      op(OP_WRITE2, CODE_PROG, (k + 3) << 12, d1);
      poll((k + 3) << 12);
      chk("lock_status", st(1'b1, 1'b0, 1'b0, k != 2, 1'b0), r);
      op(OP_WRITE1, '0, a1, 16'h0050);
      op(OP_READ, '0, (k + 3) << 12, '0);
      chk("after_clear", k == 2 ? d1 : 16'hFFFF, r);
    end
    vpp_ok <= 1'b0;
    op(OP_WRITE2, CODE_PROG, a1, 16'h0000);
    poll(a1);
    chk("vpp_low", st(1'b1, 1'b0, 1'b0, 1'b0, 1'b1), r);
    vpp_ok <= 1'b1;
    op(OP_WRITE1, '0, a1, 16'h0050);
    op(OP_CMDREAD, CODE_READ_ID, 0, '0);
    chk("maker_id", MFR, r);
    op(OP_WRITE1, '0, a1, 16'h0040);
    apb(1'b0, REG_STATUS, '0);
    chk("id_refuse", 32'h0000_0006, r);
    apb(1'b1, REG_STATUS, CLR);
    op(OP_READ, '0, 1, '0);
    chk("part_id", DEV, r);
    op(OP_WRITE1, '0, a1, 16'h00FF);
    op(OP_CMDREAD, CODE_QUERY, 32'h0000_0010, '0);
    chk("query", 16'h0041, r);
    op(OP_WRITE1, '0, a1, 16'h00FF);
    op(OP_WRITE2, CODE_PROG, a1, 16'h0000);
    op(OP_RESET, '0, '0, '0);
    op(OP_READ, '0, a1, '0);
    chk("aborted", 16'hFFFF, r);
    apb(1'b0, REG_STATUS, '0);
    chk("status_after", '0, r);
    print_verdict();
  end
endmodule // fcs_ctrl_tb_top
`default_nettype wire
